// [inc/csio_map.vh]
// register map, field positions, reset values and timing constants
// assumes inclusion by the serial port design and test files
`ifndef CSIO_MAP_VH
`define CSIO_MAP_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CSIO_IDX_CTRL 6'h0A
`define CSIO_IDX_DATA 6'h0B

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define CSIO_BIT_EF 7
`define CSIO_BIT_EIE 6
`define CSIO_BIT_RE 5
`define CSIO_BIT_TE 4
`define CSIO_SS_HI 2
`define CSIO_SS_LO 0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define CSIO_SS_RST 3'h7
`define CSIO_SS_EXT 3'h7
`define CSIO_DATA_RST 8'h00
`define CSIO_RESP_OKAY 2'h0
`define CSIO_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing: smallest divide ratio is 20, half period 10 clocks
// ----------------------------------------------------------------
`define CSIO_DIV_MIN 20
`define CSIO_HALF_BASE 10'h00A
`define CSIO_LAST_BIT 4'h7

`endif

// [design/csio_clkgen.v]
// bit clock generator: internal divider or synchronised external clock
// assumes run and restart come from logic on the same clock
`include "csio_map.vh"

module csio_clkgen (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire run,
	input wire restart,
	input wire [2:0] speed_sel,
	// raw clock pin input
	input wire sclk_pin_in,
	// bit clock events
	output reg rise_q,
	output reg fall_q,
	output reg level_q
);

	wire ext_mode;
	wire [9:0] half_cnt;
	wire half_done;
	reg [9:0] div_q;
	reg sync1_q;
	reg sync2_q;
	reg sync3_q;

	assign ext_mode = (speed_sel == `CSIO_SS_EXT);
	assign half_cnt = `CSIO_HALF_BASE << speed_sel;
	assign half_done = (div_q == half_cnt - 10'h001);

	// ----------------------------------------------------------------
	// external clock synchroniser
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
		end else begin
			sync1_q <= sclk_pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ----------------------------------------------------------------
	// divider and edge pulses
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 10'h000;
			level_q <= 1'b1;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (!run || restart) begin
			div_q <= 10'h000;
			level_q <= 1'b1;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (ext_mode) begin
			div_q <= 10'h000;
			level_q <= 1'b1;
			rise_q <= sync2_q & ~sync3_q;
			fall_q <= ~sync2_q & sync3_q;
		end else if (half_done) begin
			div_q <= 10'h000;
			level_q <= ~level_q;
			rise_q <= ~level_q;
			fall_q <= level_q;
		end else begin
			div_q <= div_q + 10'h001;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
	end

endmodule // csio_clkgen

// [design/csio_top.v]
// clocked serial port: one data register, AXI4-Lite register access
// assumes a 40 MHz CORE_CLK and a half-duplex external serial partner
//
// Summary of operation
// - data write mid-transfer replaces shift contents
// - one 8-bit data register, index 0Bh
// - speed codes 0-6 divide by 20..1280
// - code 7 selects external clock input
// - internal mode always drives clock pin, toggles it only while enabled
// - clearing the last set enable stops the transfer now
// - reset clears enables and flag, sets speed code 7, keeps data register
// - eight bits in clear receive enable, set flag
// - eight bits out clear transmit enable, set flag
// - data access or reset clears end flag
// - request while flag and interrupt enable set
`include "csio_map.vh"

module csio_top (
	// clock and reset
	input wire CORE_CLK,
	input wire RST,
	// axi4-lite write address
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	// axi4-lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read address
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	// axi4-lite read data
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// serial pins
	input wire SERIAL_CLOCK_PIN_IN,
	output reg SERIAL_CLOCK_PIN_OUT,
	output reg SERIAL_CLOCK_PIN_OE,
	output reg SERIAL_OUT_PIN,
	input wire SERIAL_IN_PIN,
	// interrupt request
	output reg END_IRQ
);

	reg aw_hold_q;
	reg [5:0] aw_idx_q;
	reg w_hold_q;
	reg [7:0] w_data_q;
	reg w_strb_q;
	reg [7:0] data_q;
	reg end_flag_q;
	reg end_irq_enable_q;
	reg rx_enable_q;
	reg tx_enable_q;
	reg [2:0] speed_sel_q;
	reg [3:0] bit_cnt_q;
	reg sdi1_q;
	reg sdi2_q;
	reg [31:0] rdata_d;
	reg rresp_err_d;
	wire aw_take;
	wire w_take;
	wire ar_take;
	wire do_wr;
	wire wr_ctrl;
	wire wr_data;
	wire rd_data;
	wire start;
	wire run;
	wire bit_rise;
	wire bit_fall;
	wire bit_level;
	wire last_bit;
	wire [7:0] ctrl_val;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_take = S_AXI_WVALID & S_AXI_WREADY;
	assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
	assign do_wr = aw_hold_q & w_hold_q & ~S_AXI_BVALID;
	assign wr_ctrl = do_wr & w_strb_q & (aw_idx_q == `CSIO_IDX_CTRL);
	assign wr_data = do_wr & w_strb_q & (aw_idx_q == `CSIO_IDX_DATA);
	assign rd_data = ar_take & (S_AXI_ARADDR[7:2] == `CSIO_IDX_DATA);
	assign ctrl_val = {end_flag_q, end_irq_enable_q, rx_enable_q,
		tx_enable_q, 1'b0, speed_sel_q};

	// a write that raises an enable from zero starts a transfer
	assign start = wr_ctrl & ((w_data_q[`CSIO_BIT_RE] & ~rx_enable_q) |
		(w_data_q[`CSIO_BIT_TE] & ~tx_enable_q));
	assign run = rx_enable_q | tx_enable_q;
	assign last_bit = bit_rise & (bit_cnt_q == `CSIO_LAST_BIT);

	always @* begin
		rdata_d = 32'h00000000;
		rresp_err_d = 1'b0;
		case (S_AXI_ARADDR[7:2])
			`CSIO_IDX_CTRL: rdata_d[7:0] = ctrl_val;
			`CSIO_IDX_DATA: rdata_d[7:0] = data_q;
			default: rresp_err_d = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			aw_hold_q <= 1'b0;
			aw_idx_q <= 6'h00;
			w_hold_q <= 1'b0;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `CSIO_RESP_OKAY;
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `CSIO_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_q <= 1'b1;
				aw_idx_q <= S_AXI_AWADDR[7:2];
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_take) begin
				w_hold_q <= 1'b1;
				w_data_q <= S_AXI_WDATA[7:0];
				w_strb_q <= S_AXI_WSTRB[0];
				S_AXI_WREADY <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (aw_idx_q == `CSIO_IDX_CTRL ||
					aw_idx_q == `CSIO_IDX_DATA) begin
					S_AXI_BRESP <= `CSIO_RESP_OKAY;
				end else begin
					S_AXI_BRESP <= `CSIO_RESP_SLVERR;
				end
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
			if (ar_take) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rdata_d;
				S_AXI_RRESP <= rresp_err_d ? `CSIO_RESP_SLVERR :
					`CSIO_RESP_OKAY;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control/status register and bit counter
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			end_flag_q <= 1'b0;
			end_irq_enable_q <= 1'b0;
			rx_enable_q <= 1'b0;
			tx_enable_q <= 1'b0;
			speed_sel_q <= `CSIO_SS_RST;
			bit_cnt_q <= 4'h0;
		end else begin
			// hardware set wins over the clear by a data access
			if (last_bit)
				end_flag_q <= 1'b1;
			else if (wr_data || rd_data)
				end_flag_q <= 1'b0;
			if (start)
				bit_cnt_q <= 4'h0;
			else if (run && bit_rise)
				bit_cnt_q <= bit_cnt_q + 4'h1;
			// a software write wins over the end-of-byte clear
			if (wr_ctrl) begin
				end_irq_enable_q <= w_data_q[`CSIO_BIT_EIE];
				rx_enable_q <= w_data_q[`CSIO_BIT_RE];
				tx_enable_q <= w_data_q[`CSIO_BIT_TE];
				speed_sel_q <= w_data_q[`CSIO_SS_HI:`CSIO_SS_LO];
			end else if (last_bit) begin
				rx_enable_q <= 1'b0;
				tx_enable_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// shared data register: no reset, contents survive RST
	// ----------------------------------------------------------------
	initial data_q = `CSIO_DATA_RST;

	always @(posedge CORE_CLK) begin
		if (wr_data)
			data_q <= w_data_q;
		else if (rx_enable_q && bit_rise)
			data_q <= {sdi2_q, data_q[7:1]};
		else if (tx_enable_q && bit_fall && bit_cnt_q != 4'h0)
			data_q <= {1'b0, data_q[7:1]};
	end

	// ----------------------------------------------------------------
	// pins and interrupt
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sdi1_q <= 1'b1;
			sdi2_q <= 1'b1;
			SERIAL_CLOCK_PIN_OUT <= 1'b1;
			SERIAL_CLOCK_PIN_OE <= 1'b0;
			SERIAL_OUT_PIN <= 1'b1;
			END_IRQ <= 1'b0;
		end else begin
			sdi1_q <= SERIAL_IN_PIN;
			sdi2_q <= sdi1_q;
			SERIAL_CLOCK_PIN_OE <= (speed_sel_q != `CSIO_SS_EXT);
			SERIAL_CLOCK_PIN_OUT <= run ? bit_level : 1'b1;
			SERIAL_OUT_PIN <= tx_enable_q ? data_q[0] : 1'b1;
			END_IRQ <= end_flag_q & end_irq_enable_q;
		end
	end

	// ----------------------------------------------------------------
	// bit clock
	// ----------------------------------------------------------------
	csio_clkgen u_clkgen (
		.clk(CORE_CLK),
		.rst(RST),
		.run(run),
		.restart(start),
		.speed_sel(speed_sel_q),
		.sclk_pin_in(SERIAL_CLOCK_PIN_IN),
		.rise_q(bit_rise),
		.fall_q(bit_fall),
		.level_q(bit_level)
	);

endmodule // csio_top

// [testbench/csio_props.sv]
// checker for bus handshakes and serial pin timing
// assumes it is bound to csio_top
module csio_props (
	// clock and reset
	input wire CORE_CLK,
	input wire RST,
	// watched outputs and bus ready inputs
	input wire S_AXI_AWREADY,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire SERIAL_CLOCK_PIN_OUT,
	input wire SERIAL_CLOCK_PIN_OE,
	input wire SERIAL_OUT_PIN,
	input wire END_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	sequence b_done;
		S_AXI_BVALID && S_AXI_BREADY;
	endsequence
	sequence r_wait;
		S_AXI_RVALID && !S_AXI_RREADY;
	endsequence
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write answer dropped");
	b_release_a: assert property (b_done |=> !S_AXI_BVALID && S_AXI_AWREADY)
		else $error("write not released");
	r_hold_a: assert property (r_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer moved");
	r_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("read upper bits set");
	clk_idle_a: assert property (!SERIAL_CLOCK_PIN_OE |-> SERIAL_CLOCK_PIN_OUT)
		else $error("clock moved while input");
	clk_low_a: assert property ($fell(SERIAL_CLOCK_PIN_OUT) |-> (!SERIAL_CLOCK_PIN_OUT)[*8])
		else $error("clock low phase short");
	tx_stable_a: assert property ($rose(SERIAL_CLOCK_PIN_OUT) |-> $stable(SERIAL_OUT_PIN))
		else $error("data moved at rise");
	irq_end_a: assert property ($rose(END_IRQ) |-> SERIAL_CLOCK_PIN_OUT)
		else $error("request mid byte");
endmodule // csio_props

bind csio_top csio_props chk (.CORE_CLK, .RST, .S_AXI_AWREADY, .S_AXI_BVALID,
	.S_AXI_BREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY,
	.SERIAL_CLOCK_PIN_OUT, .SERIAL_CLOCK_PIN_OE, .SERIAL_OUT_PIN, .END_IRQ);

// [testbench/csio_peer.sv]
// serial partner sharing the clock line
// assumes the port drives the clock, idling high
module csio_peer (
	// link lines
	input wire clk_line,
	input wire oe,
	input wire dout,
	output wire din,
	// test side
	input wire load,
	input wire [7:0] tx_byte,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh_q = 8'h00;
	logic seen_q = 1'b0;
	// unselected line shows the inverse, not a stale bit
	assign din = oe ? sh_q[0] : ~sh_q[0];
	// next bit on each fall after the first
	always @(negedge clk_line or posedge load) begin
		if (load) begin
			sh_q <= tx_byte;
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
			if (seen_q)
				sh_q <= {sh_q[0], sh_q[7:1]};
		end
	end
	// bits taken on each rise, first lands lowest
	always @(posedge clk_line)
		rx_byte <= {dout, rx_byte[7:1]};
endmodule // csio_peer

// [testbench/clocked_serial_io_port_test.sv]
// self-checking bench for the serial port
// assumes csio_top, csio_peer and the bound checker
`include "csio_map.vh"
module clocked_serial_io_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, ld = 0, psel = 0, ext_ck = 1;
	logic [7:0] awaddr = 0, araddr = 0, pb = 0, d, prx;
	logic [31:0] wdata = 0, rdata, rd_q;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, ck_out, ck_oe, sout, sin, irq;
	logic [1:0] bresp, rresp, rr_q;
	wire ck_line = ck_oe ? ck_out : ext_ck;
	int err_total = 0, num_checks = 0, n;
	localparam [7:0] A_CTRL = {`CSIO_IDX_CTRL, 2'b00};
	localparam [7:0] A_DATA = {`CSIO_IDX_DATA, 2'b00};
	initial forever #12.5 clk = ~clk;
	csio_top uut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SERIAL_CLOCK_PIN_IN(ck_line),
		.SERIAL_CLOCK_PIN_OUT(ck_out), .SERIAL_CLOCK_PIN_OE(ck_oe),
		.SERIAL_OUT_PIN(sout), .SERIAL_IN_PIN(sin), .END_IRQ(irq));
	csio_peer peer (.clk_line(ck_line), .oe(psel), .dout(sout), .din(sin),
		.load(ld), .tx_byte(pb), .rx_byte(prx));
	// ----
	// helpers
	// ----
	function automatic int byte_len(input int c);
		return 8 * (20 << c);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, `CSIO_RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd_q = rdata;
		rr_q = rresp;
		rready <= 1'b0;
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#(25 * 80000);
		err_total++;
		complete_run;
	end
	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(32'hd99e));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk(ck_oe, 0);
		rd(A_CTRL);
		chk(rd_q, 32'h07);
		rd(8'h00);
		chk(rr_q, `CSIO_RESP_SLVERR);
		for (int c = 0; c < 7; c++) begin
			d = 8'($urandom);
			wr(A_DATA, d);
			wr(A_CTRL, 8'(c));
			wr(A_CTRL, 8'h50 | 8'(c));
			chk(ck_oe, 1);
			n = 0;
			while (irq !== 1'b1 && n < 30000) begin
				@(posedge clk);
				n++;
			end
			chk(n + 4 >= byte_len(c) && n <= byte_len(c) + 4, 1);
			chk(prx, d);
			rd(A_CTRL);
			chk(rd_q, 8'hC0 | 8'(c));
			rd(A_DATA);
			chk(rd_q, 32'(d[7]));
			rd(A_CTRL);
			chk(rd_q, 8'h40 | 8'(c));
			chk(irq, 0);
			wr(A_CTRL, 8'(c));
			repeat (20 << c) @(posedge clk);
		end
		pb <= 8'($urandom);
		psel <= 1'b1;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		wr(A_CTRL, 8'h00);
		wr(A_CTRL, 8'h20);
		n = 0;
		do begin
			rd(A_CTRL);
			n++;
		end while (rd_q[5] && n < 400);
		chk(rd_q, 8'h80);
		chk(irq, 0);
		rd(A_DATA);
		chk(rd_q, pb);
		wr(A_CTRL, 8'h10);
		@(posedge ck_out);
		wr(A_CTRL, 8'h00);
		repeat (200) @(posedge clk);
		rd(A_CTRL);
		chk(rd_q, 8'h00);
		chk(ck_out, 1);
		chk(sout, 1);
		d = 8'($urandom);
		wr(A_DATA, d);
		wr(A_CTRL, 8'h10);
		repeat (22) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		chk(ck_oe, 0);
		rd(A_CTRL);
		chk(rd_q, 32'h07);
		rd(A_DATA);
		chk(rd_q, d);
		pb <= 8'($urandom);
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		wr(A_CTRL, 8'h67);
		repeat (8) begin
			repeat (20) @(posedge clk);
			ext_ck <= 1'b0;
			repeat (20) @(posedge clk);
			ext_ck <= 1'b1;
		end
		repeat (8) @(posedge clk);
		chk(irq, 1);
		rd(A_DATA);
		chk(rd_q, pb);
		wr(A_CTRL, 8'h67);
		rd(A_CTRL);
		chk(rd_q, 8'h67);
		complete_run;
	end
endmodule // clocked_serial_io_port_test
